// >>> inc/output_turn_on_sequencer_consts.svh
// constants for the output turn-on sequencer
`ifndef OUTPUT_TURN_ON_SEQUENCER_CONSTS_SVH
`define OUTPUT_TURN_ON_SEQUENCER_CONSTS_SVH

// timebase
`define OTS_CLK_HZ 25000000
`define OTS_TICK_MS 1
`define OTS_TICK_CYCLES (`OTS_CLK_HZ / 1000 * `OTS_TICK_MS)

// command codes
`define OTS_CMD_CLEAR_FAULTS 8'h03
`define OTS_CMD_PG_LOW 8'h5F
`define OTS_CMD_DELAY 8'h60
`define OTS_CMD_RISE 8'h61
`define OTS_CMD_TMO_LIMIT 8'h62
`define OTS_CMD_TMO_RESP 8'h63

// fields of the timeout action byte
`define OTS_RESP_HI 7
`define OTS_RESP_LO 6
`define OTS_RETRY_HI 5
`define OTS_RETRY_LO 3
`define OTS_DLY_HI 2
`define OTS_DLY_LO 0
`define OTS_RETRY_NONE 3'h0
`define OTS_RETRY_FOREVER 3'h7

// reset values
`define OTS_RST_PG_LOW 16'h0000
`define OTS_RST_DELAY 16'h0000
`define OTS_RST_RISE 16'h0000
`define OTS_RST_TMO_LIMIT 16'h0000
`define OTS_RST_TMO_RESP 8'h00

`endif

// >>> inc/ots_pkg.sv
// types for the output turn-on sequencer
package ots_pkg;

  typedef enum {
    S_OFF,
    S_DELAY,
    S_RAMP,
    S_ON,
    S_GRACE,
    S_RETRY_WAIT,
    S_LATCHED
  } seq_state_t;

  typedef enum logic [1:0] {
    RESP_IGNORE,
    RESP_RETRY_RUN,
    RESP_DISABLE_RETRY,
    RESP_LATCH
  } resp_t;

endpackage : ots_pkg

// >>> inc/tick_if.sv
// millisecond tick carried from the timebase to the sequencer
`timescale 1ns/1ns
interface tick_if;
  logic tick;
  modport src (output tick);
  modport dst (input tick);
endinterface : tick_if

// >>> verilog/ms_tick.sv
// millisecond tick generator
`timescale 1ns/1ns
module ms_tick #(
  parameter int unsigned CYCLES = 25000
) (
  // clock and reset
  input wire logic clk,
  input wire logic rstn,
  // tick out
  tick_if.src tif
);

  localparam int CW = $clog2(CYCLES + 1);

  logic [CW-1:0] cnt;
  wire wrap = (cnt == CW'(CYCLES - 1));

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      cnt <= '0;
      tif.tick <= 1'b0;
    end else begin
      cnt <= wrap ? '0 : cnt + CW'(1);
      tif.tick <= wrap;
    end
  end

  chk_tick_single: assert property (@(posedge clk) disable iff (!rstn)
    tif.tick && (CYCLES > 1) |=> !tif.tick)
    else $error("tick lasted more than one cycle");

endmodule : ms_tick

// >>> verilog/output_turn_on_sequencer.sv
// output turn-on sequencer with timeout fault handling
//
// What this block does
// - hold power-good low threshold, drop flag below
// - wait programmed ms delay before ramp start
// - ramp output over programmed ms rise time
// - timeout fault if undervoltage limit not reached
// - zero timeout limit means never fault
// - action 00 ignores; 01 runs delay then retries
// - action 10 disables immediately, then retries
// - action 11 disables until fault cleared
// - clear latch by clear, command, reset, off-on
// - retry field 000 means no restart
// - retry 001 once, 010 twice
// - retries exhausted: stay off until cleared
// - restart spacing is delay count times unit
// - delay count is two to field value
// - 011-110 three to six, 111 unlimited
`timescale 1ns/1ns
`include "output_turn_on_sequencer_consts.svh"
module output_turn_on_sequencer #(
  parameter int unsigned TICK_CYCLES = `OTS_TICK_CYCLES
) (
  // clock and reset
  input wire logic clk,
  input wire logic rstn,
  // command port
  input wire logic cmd_wr,
  input wire logic cmd_rd,
  input wire logic [7:0] cmd_code,
  input wire logic [15:0] cmd_wdata,
  output logic [15:0] cmd_rdata,
  output logic cmd_ack,
  output logic cmd_err,
  // control and sense pins
  input wire logic enable_pin,
  input wire logic uv_ok_pin,
  // on-chip inputs
  input wire logic [15:0] vout_code,
  input wire logic [7:0] retry_unit_ms,
  input wire logic fault_bit_clear,
  // outputs
  output logic output_on,
  output logic ramp_active,
  output logic supply_ok_flag,
  output logic timeout_fault,
  output logic [2:0] retry_count
);

  ////////////////////////////////////////////////////////////////////////
  // timebase

  tick_if tif ();

  ms_tick #(
    .CYCLES(TICK_CYCLES)
  ) u_tick (
    .clk(clk),
    .rstn(rstn),
    .tif(tif)
  );

  wire tick = tif.tick;

  ////////////////////////////////////////////////////////////////////////
  // pin synchronisers

  logic en_meta;
  logic en_s;
  logic uv_meta;
  logic uv_s;

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      en_meta <= 1'b0;
      en_s <= 1'b0;
      uv_meta <= 1'b0;
      uv_s <= 1'b0;
    end else begin
      en_meta <= enable_pin;
      en_s <= en_meta;
      uv_meta <= uv_ok_pin;
      uv_s <= uv_meta;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // command registers

  logic [15:0] pg_low;
  logic [15:0] ramp_start_delay;
  logic [15:0] ramp_duration;
  logic [15:0] tmo_limit;
  logic [7:0] tmo_resp;

  wire hit_clear = (cmd_code == `OTS_CMD_CLEAR_FAULTS);
  wire hit_pg = (cmd_code == `OTS_CMD_PG_LOW);
  wire hit_dly = (cmd_code == `OTS_CMD_DELAY);
  wire hit_rise = (cmd_code == `OTS_CMD_RISE);
  wire hit_lim = (cmd_code == `OTS_CMD_TMO_LIMIT);
  wire hit_resp = (cmd_code == `OTS_CMD_TMO_RESP);
  wire hit_reg = hit_pg | hit_dly | hit_rise | hit_lim | hit_resp;
  wire wr_ok = cmd_wr & (hit_reg | hit_clear);
  wire rd_ok = cmd_rd & hit_reg;
  wire clear_cmd = cmd_wr & hit_clear;

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      pg_low <= `OTS_RST_PG_LOW;
      ramp_start_delay <= `OTS_RST_DELAY;
      ramp_duration <= `OTS_RST_RISE;
      tmo_limit <= `OTS_RST_TMO_LIMIT;
      tmo_resp <= `OTS_RST_TMO_RESP;
    end else if (cmd_wr) begin
      if (hit_pg) pg_low <= cmd_wdata;
      if (hit_dly) ramp_start_delay <= cmd_wdata;
      if (hit_rise) ramp_duration <= cmd_wdata;
      if (hit_lim) tmo_limit <= cmd_wdata;
      if (hit_resp) tmo_resp <= cmd_wdata[7:0];
    end
  end

  logic [15:0] rd_mux;

  always_comb begin
    if (hit_pg) rd_mux = pg_low;
    else if (hit_dly) rd_mux = ramp_start_delay;
    else if (hit_rise) rd_mux = ramp_duration;
    else if (hit_lim) rd_mux = tmo_limit;
    else if (hit_resp) rd_mux = {8'h00, tmo_resp};
    else rd_mux = 16'h0000;
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      cmd_rdata <= 16'h0000;
      cmd_ack <= 1'b0;
      cmd_err <= 1'b0;
    end else begin
      cmd_rdata <= rd_ok ? rd_mux : 16'h0000;
      cmd_ack <= wr_ok | rd_ok;
      cmd_err <= (cmd_wr & ~wr_ok) | (cmd_rd & ~rd_ok);
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // decoded settings

  wire ots_pkg::resp_t resp = ots_pkg::resp_t'(tmo_resp[`OTS_RESP_HI:`OTS_RESP_LO]);
  wire [2:0] retries = tmo_resp[`OTS_RETRY_HI:`OTS_RETRY_LO];
  wire [2:0] dly_code = tmo_resp[`OTS_DLY_HI:`OTS_DLY_LO];

  // two to the field, in units
  wire [15:0] spacing = 16'({8'h00, retry_unit_ms} << dly_code);

  ////////////////////////////////////////////////////////////////////////
  // sequencer state

  ots_pkg::seq_state_t state;
  ots_pkg::seq_state_t next_state;
  logic [15:0] ms_cnt;
  logic [15:0] tmo_cnt;
  logic uv_reached;
  logic tmo_done;
  logic [2:0] attempts;

  wire clear_req = clear_cmd | fault_bit_clear;
  wire powered = (state == ots_pkg::S_RAMP) | (state == ots_pkg::S_ON) | (state == ots_pkg::S_GRACE);
  wire delay_done = (ms_cnt >= ramp_start_delay);
  wire rise_done = (ms_cnt >= ramp_duration);
  wire space_done = (ms_cnt >= spacing);

  // window from ramp start to crossing
  wire tmo_active = powered & ~uv_reached;

  wire tmo_hit = tmo_active & ~tmo_done & ~uv_s & (tmo_limit != 16'h0000) & (tmo_cnt >= tmo_limit);

  wire retry_ok = (retries != `OTS_RETRY_NONE) & ((retries == `OTS_RETRY_FOREVER) | (attempts < retries));

  // no retry goes straight to latch
  ots_pkg::seq_state_t fail_state;
  assign fail_state = retry_ok ? ots_pkg::S_RETRY_WAIT : ots_pkg::S_LATCHED;

  ots_pkg::seq_state_t fault_state;

  always_comb begin
    case (resp)
      ots_pkg::RESP_IGNORE: fault_state = state;
      ots_pkg::RESP_RETRY_RUN: fault_state = ots_pkg::S_GRACE;
      ots_pkg::RESP_DISABLE_RETRY: fault_state = fail_state;
      default: fault_state = ots_pkg::S_LATCHED;
    endcase
  end

  always_comb begin
    next_state = state;
    case (state)
      ots_pkg::S_OFF: begin
        next_state = ots_pkg::S_DELAY;
      end
      ots_pkg::S_DELAY: begin
        if (delay_done) next_state = ots_pkg::S_RAMP;
      end
      ots_pkg::S_RAMP: begin
        if (tmo_hit) next_state = fault_state;
        else if (rise_done) next_state = ots_pkg::S_ON;
      end
      ots_pkg::S_ON: begin
        if (tmo_hit) next_state = fault_state;
      end
      ots_pkg::S_GRACE: begin
        if (space_done) next_state = uv_s ? ots_pkg::S_ON : fail_state;
      end
      ots_pkg::S_RETRY_WAIT: begin
        if (space_done) next_state = ots_pkg::S_DELAY;
      end
      ots_pkg::S_LATCHED: begin
        if (clear_req) next_state = ots_pkg::S_OFF;
      end
      default: begin
        next_state = ots_pkg::S_OFF;
      end
    endcase
    if (!en_s) next_state = ots_pkg::S_OFF;
  end

  wire state_chg = (next_state != state);
  wire ramp_enter = (state == ots_pkg::S_DELAY) & (next_state == ots_pkg::S_RAMP);
  wire restart = (state == ots_pkg::S_RETRY_WAIT) & (next_state == ots_pkg::S_DELAY);
  wire next_on = (next_state == ots_pkg::S_RAMP) | (next_state == ots_pkg::S_ON) |
                 (next_state == ots_pkg::S_GRACE);

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) state <= ots_pkg::S_OFF;
    else state <= next_state;
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) ms_cnt <= 16'h0000;
    else if (state_chg) ms_cnt <= 16'h0000;
    else if (tick && ms_cnt != 16'hFFFF) ms_cnt <= ms_cnt + 16'h0001;
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) tmo_cnt <= 16'h0000;
    else if (ramp_enter) tmo_cnt <= 16'h0000;
    else if (tmo_active && tick && tmo_cnt != 16'hFFFF) tmo_cnt <= tmo_cnt + 16'h0001;
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      uv_reached <= 1'b0;
      tmo_done <= 1'b0;
    end else if (ramp_enter) begin
      uv_reached <= 1'b0;
      tmo_done <= 1'b0;
    end else begin
      uv_reached <= uv_reached | (powered & uv_s);
      tmo_done <= tmo_done | tmo_hit;
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) attempts <= 3'h0;
    else if (!en_s || clear_req) attempts <= 3'h0;
    else if (restart && attempts != 3'h7) attempts <= attempts + 3'h1;
  end

  // sticky fault, set wins over clear
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) timeout_fault <= 1'b0;
    else if (tmo_hit) timeout_fault <= 1'b1;
    else if (clear_req || !en_s) timeout_fault <= 1'b0;
  end

  ////////////////////////////////////////////////////////////////////////
  // outputs

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      output_on <= 1'b0;
      ramp_active <= 1'b0;
      supply_ok_flag <= 1'b0;
      retry_count <= 3'h0;
    end else begin
      output_on <= next_on;
      ramp_active <= (next_state == ots_pkg::S_RAMP);
      supply_ok_flag <= (state == ots_pkg::S_ON) & (vout_code >= pg_low);
      retry_count <= attempts;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // checks

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rstn);

  chk_pg_drop: assert property (
    state == ots_pkg::S_ON && vout_code < pg_low |=> !supply_ok_flag)
    else $error("power-good flag held below threshold");

  chk_delay_exit: assert property (
    state == ots_pkg::S_DELAY ##1 state == ots_pkg::S_RAMP |-> $past(ms_cnt) >= $past(ramp_start_delay))
    else $error("ramp started before turn-on delay");

  chk_rise_exit: assert property (
    state == ots_pkg::S_RAMP ##1 state == ots_pkg::S_ON |-> $past(ms_cnt) >= $past(ramp_duration))
    else $error("ramp ended before rise time");

  chk_fault_cause: assert property (
    $rose(timeout_fault) |-> $past(tmo_cnt) >= $past(tmo_limit) && !$past(uv_s))
    else $error("timeout fault without expired limit");

  chk_zero_limit: assert property (
    $rose(timeout_fault) |-> $past(tmo_limit) != 16'h0000)
    else $error("timeout fault with zero limit");

  chk_ignore_runs: assert property (
    tmo_hit && en_s && resp == ots_pkg::RESP_IGNORE |=> output_on && timeout_fault)
    else $error("ignore action interrupted output");

  chk_disable_now: assert property (
    tmo_hit && resp == ots_pkg::RESP_DISABLE_RETRY |=> !output_on)
    else $error("disable action left output on");

  chk_latch_off: assert property (
    state == ots_pkg::S_LATCHED |-> !output_on)
    else $error("output on while latched");

  chk_clear_unlatch: assert property (
    state == ots_pkg::S_LATCHED && clear_req |=> state == ots_pkg::S_OFF)
    else $error("clear did not release latch");

  chk_no_retry: assert property (
    tmo_hit && en_s && resp == ots_pkg::RESP_DISABLE_RETRY && retries == `OTS_RETRY_NONE
    |=> state == ots_pkg::S_LATCHED)
    else $error("restart attempted with retry none");

  chk_retry_bound: assert property (
    restart && $past(retries) != `OTS_RETRY_FOREVER |=> attempts <= retries)
    else $error("more restarts than allowed");

  chk_retry_space: assert property (
    state == ots_pkg::S_RETRY_WAIT ##1 state == ots_pkg::S_DELAY |-> $past(ms_cnt) >= $past(spacing))
    else $error("restart came before spacing");

endmodule : output_turn_on_sequencer

// >>> dv/pmbus_host_model.sv
// host model issuing configuration commands
`timescale 1ns/1ns
module pmbus_host_model (
  // clock
  input wire logic clk,
  // command side
  output logic cmd_wr,
  output logic cmd_rd,
  output logic [7:0] cmd_code,
  output logic [15:0] cmd_wdata,
  // answer side
  input wire logic [15:0] cmd_rdata,
  input wire logic cmd_ack,
  input wire logic cmd_err
);
  initial begin
    cmd_wr = 1'b0;
    cmd_rd = 1'b0;
    cmd_code = 8'h00;
    cmd_wdata = 16'h0000;
  end
  ////////////////////////////////////////
  // one access; answer is registered at the taking edge and read at the next falling edge
  task automatic access(input logic w, input logic [7:0] c, input logic [15:0] d,
                        output logic a, output logic e, output logic [15:0] r);
    @(posedge clk);
    cmd_wr <= w;
    cmd_rd <= !w;
    cmd_code <= c;
    cmd_wdata <= d;
    @(posedge clk);
    cmd_wr <= 1'b0;
    cmd_rd <= 1'b0;
    // released lines do not keep the last value
    cmd_code <= ~c;
    cmd_wdata <= ~d;
    @(negedge clk);
    a = cmd_ack;
    e = cmd_err;
    r = cmd_rdata;
  endtask : access
endmodule : pmbus_host_model

// >>> dv/tb.sv
// self-checking bench for the output turn-on sequencer
`timescale 1ns/1ns
module tb;
  localparam int TC = 4;
  logic clk, rstn, enable_pin, uv_ok_pin, fault_bit_clear, cmd_wr, cmd_rd, cmd_ack, cmd_err;
  logic output_on, ramp_active, supply_ok_flag, timeout_fault;
  logic [7:0] cmd_code, retry_unit_ms;
  logic [15:0] cmd_wdata, cmd_rdata, vout_code;
  logic [2:0] retry_count;
  int err_total = 0;
  int comparisons = 0;
  output_turn_on_sequencer #(.TICK_CYCLES(TC)) uut (.clk(clk), .rstn(rstn), .cmd_wr(cmd_wr),
    .cmd_rd(cmd_rd), .cmd_code(cmd_code), .cmd_wdata(cmd_wdata), .cmd_rdata(cmd_rdata),
    .cmd_ack(cmd_ack), .cmd_err(cmd_err), .enable_pin(enable_pin), .uv_ok_pin(uv_ok_pin),
    .vout_code(vout_code), .retry_unit_ms(retry_unit_ms), .fault_bit_clear(fault_bit_clear),
    .output_on(output_on), .ramp_active(ramp_active), .supply_ok_flag(supply_ok_flag),
    .timeout_fault(timeout_fault), .retry_count(retry_count));
  pmbus_host_model host (.clk(clk), .cmd_wr(cmd_wr), .cmd_rd(cmd_rd), .cmd_code(cmd_code),
    .cmd_wdata(cmd_wdata), .cmd_rdata(cmd_rdata), .cmd_ack(cmd_ack), .cmd_err(cmd_err));
  ////////////////////////////////////////
  task automatic final_report;
    $display("mismatches %0d comparisons %0d", err_total, comparisons);
    if (err_total == 0 && comparisons > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask : final_report
  task automatic chk(input logic [15:0] exp, input logic [15:0] got);
    comparisons++;
    if (got !== exp) begin
      err_total++;
      $display("unexpected at %0t: expected %h got %h", $time, exp, got);
    end
  endtask : chk
  task automatic chk_span(input int lo, input int hi, input int n);
    comparisons++;
    if (n < lo || n > hi) begin
      err_total++;
      $display("unexpected at %0t: span %h outside %h to %h", $time, n, lo, hi);
    end
  endtask : chk_span
  task automatic acc(input logic w, input logic [7:0] c, input logic [15:0] d, input logic [1:0] ea,
                     input logic [15:0] rexp);
    logic a, e;
    logic [15:0] r;
    host.access(w, c, d, a, e, r);
    chk({14'h0000, ea}, {14'h0000, e, a});
    if (!w) chk(rexp, r);
  endtask : acc
  function automatic logic pick(input int sel);
    case (sel)
      0: pick = output_on;
      1: pick = ramp_active;
      2: pick = timeout_fault;
      default: pick = supply_ok_flag;
    endcase
  endfunction : pick
  task automatic span(input int sel, input logic lvl, output int n);
    n = 0;
    while (pick(sel) !== lvl && n < 3000) begin
      @(posedge clk);
      #1;
      n++;
    end
  endtask : span
  task automatic en(input logic v);
    @(posedge clk);
    enable_pin <= v;
  endtask : en
  task automatic cfg(input logic [15:0] dly, input logic [15:0] rise, input logic [15:0] lim,
                     input logic [7:0] act);
    acc(1'b1, 8'h60, dly, 2'h1, 16'h0000);
    acc(1'b1, 8'h61, rise, 2'h1, 16'h0000);
    acc(1'b1, 8'h62, lim, 2'h1, 16'h0000);
    acc(1'b1, 8'h63, {8'h00, act}, 2'h1, 16'h0000);
  endtask : cfg
  task automatic off_chk;
    int n;
    en(1'b0);
    span(0, 1'b0, n);
    chk_span(0, 4, n);
    repeat (3) @(posedge clk);
    #1;
    chk(16'h0000, {15'h0000, timeout_fault});
  endtask : off_chk
  // start with a short limit and a long ramp, return at the fault
  task automatic arm(input logic [7:0] act, input logic [7:0] unit);
    int n;
    cfg(16'h0000, 16'h0008, 16'h0002, act);
    en(1'b1);
    uv_ok_pin <= 1'b0;
    retry_unit_ms <= unit;
    span(0, 1'b1, n);
    span(2, 1'b1, n);
    chk_span(TC, 2 * TC + 3, n);
  endtask : arm
  ////////////////////////////////////////
  task automatic t_regs;
    logic [7:0] c;
    logic [15:0] d;
    for (int i = 0; i < 5; i++) begin
      c = 8'h5f + 8'(i);
      d = 16'ha5c0 | 16'(i);
      acc(1'b0, c, 16'h0000, 2'h1, 16'h0000);
      acc(1'b1, c, d, 2'h1, 16'h0000);
      acc(1'b0, c, 16'h0000, 2'h1, (i == 4) ? {8'h00, d[7:0]} : d);
    end
    acc(1'b0, 8'h64, 16'h0000, 2'h2, 16'h0000);
    acc(1'b0, 8'h03, 16'h0000, 2'h2, 16'h0000);
  endtask : t_regs
  task automatic t_turn_on;
    int n;
    cfg(16'h0003, 16'h0004, 16'h0002, 8'hc0);
    acc(1'b1, 8'h5f, 16'h1000, 2'h1, 16'h0000);
    en(1'b1);
    uv_ok_pin <= 1'b1;
    vout_code <= 16'h1000;
    span(0, 1'b1, n);
    chk_span(3 * TC, 4 * TC + 5, n);
    chk(16'h0001, {15'h0000, ramp_active});
    span(1, 1'b0, n);
    chk_span(3 * TC, 4 * TC + 2, n);
    span(3, 1'b1, n);
    chk_span(0, 2, n);
    @(posedge clk);
    vout_code <= 16'h0fff;
    span(3, 1'b0, n);
    chk_span(0, 3, n);
    chk(16'h0001, {15'h0000, output_on});
    chk(16'h0000, {15'h0000, timeout_fault});
    off_chk();
  endtask : t_turn_on
  task automatic t_no_limit;
    cfg(16'h0000, 16'h0002, 16'h0000, 8'hc0);
    en(1'b1);
    uv_ok_pin <= 1'b0;
    repeat (40 * TC) @(posedge clk);
    #1;
    chk(16'h0002, {14'h0000, output_on, timeout_fault});
    off_chk();
  endtask : t_no_limit
  task automatic t_ignore;
    arm(8'h00, 8'h01);
    repeat (10 * TC) @(posedge clk);
    #1;
    chk(16'h0003, {14'h0000, output_on, timeout_fault});
    off_chk();
  endtask : t_ignore
  task automatic t_grace;
    int n;
    arm(8'h41, 8'h01);
    span(0, 1'b0, n);
    chk_span(TC, 2 * TC + 3, n);
    repeat (20 * TC) @(posedge clk);
    #1;
    chk(16'h0001, {14'h0000, output_on, timeout_fault});
    acc(1'b1, 8'h03, 16'h0000, 2'h1, 16'h0000);
    chk(16'h0000, {15'h0000, timeout_fault});
    off_chk();
  endtask : t_grace
  task automatic t_latch;
    int n;
    arm(8'hc0, 8'h01);
    span(0, 1'b0, n);
    chk_span(0, 2, n);
    repeat (20 * TC) @(posedge clk);
    #1;
    chk(16'h0001, {14'h0000, output_on, timeout_fault});
    @(posedge clk);
    fault_bit_clear <= 1'b1;
    @(posedge clk);
    fault_bit_clear <= 1'b0;
    #1;
    chk(16'h0000, {15'h0000, timeout_fault});
    en(1'b0);
    repeat (4) @(posedge clk);
    en(1'b1);
    span(0, 1'b1, n);
    chk_span(1, 4 * TC, n);
    off_chk();
  endtask : t_latch
  task automatic t_retry(input logic [2:0] code);
    int rises;
    logic prev;
    arm({2'h2, code, 3'h0}, 8'h01);
    rises = 0;
    prev = output_on;
    repeat (100 * TC) begin
      @(posedge clk);
      #1;
      if (output_on && !prev) rises++;
      prev = output_on;
    end
    if (code == 3'h7) begin
      chk_span(10, 1000, rises);
    end else begin
      chk_span(code, code, rises);
      chk({13'h0000, code}, {13'h0000, retry_count});
      chk(16'h0001, {14'h0000, output_on, timeout_fault});
    end
    off_chk();
  endtask : t_retry
  task automatic t_spacing(input logic [2:0] field, input logic [7:0] unit);
    int n, s;
    s = int'(unit) << field;
    arm({5'h11, field}, unit);
    span(0, 1'b0, n);
    span(0, 1'b1, n);
    chk_span((s - 1) * TC, s * TC + 6, n);
    off_chk();
  endtask : t_spacing
  ////////////////////////////////////////
  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end
  initial begin
    rstn = 1'b0;
    enable_pin = 1'b0;
    uv_ok_pin = 1'b0;
    fault_bit_clear = 1'b0;
    vout_code = 16'h0000;
    retry_unit_ms = 8'h01;
    repeat (16) @(posedge clk);
    rstn <= 1'b1;
    t_regs();
    t_turn_on();
    t_no_limit();
    t_ignore();
    t_grace();
    t_latch();
    for (int k = 0; k < 8; k++) begin
      t_retry(3'(k));
    end
    t_spacing(3'h2, 8'h03);
    t_spacing(3'h7, 8'h01);
    t_spacing(3'h0, 8'h02);
    final_report();
  end
  initial begin
    #(40 * 40000);
    err_total++;
    final_report();
  end
endmodule : tb
